// file: src/init_pkg.sv
// Package: constants and carrier types for power-up init and address select
package init_pkg;
  localparam int           ADDR_W            = 7;
  localparam int           CODE_W            = 10;
  localparam int           CFG_W             = 16;
  localparam int           NV_DEPTH          = 8;
  localparam int           NV_AW             = 3;
  localparam int           OFFSET_BANDS      = 16;
  localparam logic [6:0]   TWO_WIRE_RESET    = 7'h10;
  localparam logic [6:0]   MGMT_BUS_RESET    = 7'h40;
  // Working-register slots holding the two base addresses
  localparam logic [2:0]   TWO_WIRE_SLOT     = 3'h0;
  localparam logic [2:0]   MGMT_BUS_SLOT     = 3'h1;
  // Converter codes per offset band; above the top band means floating strap
  localparam logic [9:0]   BAND_STEP         = 10'h03C;
  localparam logic [9:0]   BAND_TOP          = 10'h3BF;
  localparam int           OSC_MHZ           = 48;
  localparam int           CLK_MHZ           = 100;
  localparam int           ADC_SETTLE_NS     = 2000;
  localparam int           ADC_SETTLE_CYC    = (ADC_SETTLE_NS * CLK_MHZ + 999) / 1000;

  typedef struct packed {
    logic       bias_good;
    logic       core_good;
    logic       osc_stable;
  } supply_s;

  typedef struct packed {
    logic       enable_mode_pin;
    logic       bus_voltage_ok;
    logic       sw_override;
    logic       sw_enable;
  } enable_s;

  typedef struct packed {
    logic       valid;
    logic [6:0] addr;
    logic       is_mgmt;
  } bus_addr_s;
endpackage

// file: src/strap_decoder.sv
// Strap decoder: converter code to address offset or floating indication
`timescale 1ns/1ps
module strap_decoder
  import init_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              rst_b,
  input  wire logic              sample,
  input  wire logic [CODE_W-1:0] code,
  output logic                   done,
  output logic [3:0]             offset,
  output logic                   floating
);
  logic [3:0] next_offset;

  always_comb begin
    next_offset = 4'h0;
    for (int i = 1; i < OFFSET_BANDS; i++) begin
      if (code >= 10'(i * int'(BAND_STEP))) begin
        next_offset = 4'(i);
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      done     <= 1'b0;
      offset   <= 4'h0;
      floating <= 1'b0;
    end else begin
      // One-cycle pulse so a restart never reuses a stale reading
      done <= sample;
      if (sample) begin
        offset   <= next_offset;
        floating <= (code > BAND_TOP);
      end
    end
  end
endmodule // strap_decoder

// file: src/power_up_init_and_address_select.sv
// Top: power-up reset hold, nonvolatile load, strap read, mode and enable gating
`timescale 1ns/1ps
module power_up_init_and_address_select
  import init_pkg::*;
#(
  parameter int DEPTH = NV_DEPTH,
  parameter int SETTLE = ADC_SETTLE_CYC
) (
  input  wire logic              clk,
  input  wire logic              rst_b,
  input  wire supply_s           supplies,
  input  wire enable_s           enables,
  // Nonvolatile memory read port, one cycle latency
  output logic [NV_AW-1:0]       nv_addr,
  output logic                   nv_read,
  input  wire logic [CFG_W-1:0]  nv_data,
  // Strap converter
  output logic                   adc_start,
  input  wire logic              adc_valid,
  input  wire logic [CODE_W-1:0] adc_code,
  // Bus command write into working registers
  input  wire logic              cmd_write,
  input  wire logic [NV_AW-1:0]  cmd_slot,
  input  wire logic [CFG_W-1:0]  cmd_data,
  input  wire bus_addr_s         rx_addr,
  output logic                   addr_match,
  output logic                   digital_mode,
  output logic                   analog_pins,
  output logic                   load_done,
  output logic                   addr_read,
  output logic                   convert_enable,
  output logic [ADDR_W-1:0]      two_wire_address,
  output logic [ADDR_W-1:0]      mgmt_bus_address,
  output logic [CFG_W-1:0]       cfg_word [DEPTH]
);
  typedef enum logic [2:0] {HOLD, LOAD, SETTLE_W, CONVERT, DONE} init_e;

  init_e               state;
  logic                por_ok;
  logic [NV_AW-1:0]    load_idx;
  logic                load_pend;
  logic [NV_AW-1:0]    pend_idx;
  logic [15:0]         settle_cnt;
  logic                strap_done;
  logic [3:0]          strap_offset;
  logic                strap_float;
  logic [ADDR_W-1:0]   eff_two_wire;
  logic [ADDR_W-1:0]   eff_mgmt;
  logic                cmd_ok;

  function automatic logic [ADDR_W-1:0] add_offset(input logic [ADDR_W-1:0] base, input logic [3:0] off);
    add_offset = (base == '0) ? '0 : ADDR_W'(base + {3'h0, off});
  endfunction

  strap_decoder u_strap (
    .clk      (clk),
    .rst_b    (rst_b),
    .sample   (adc_valid && state == CONVERT),
    .code     (adc_code),
    .done     (strap_done),
    .offset   (strap_offset),
    .floating (strap_float)
  );

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      por_ok <= 1'b0;
    end else begin
      por_ok <= supplies.bias_good && supplies.core_good && supplies.osc_stable;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state      <= HOLD;
      load_idx   <= '0;
      settle_cnt <= '0;
      nv_read    <= 1'b0;
      nv_addr    <= '0;
      adc_start  <= 1'b0;
    end else begin
      nv_read   <= 1'b0;
      adc_start <= 1'b0;
      unique case (state)
        HOLD: begin
          if (por_ok) begin
            state    <= LOAD;
            load_idx <= '0;
          end
        end
        LOAD: begin
          nv_read  <= 1'b1;
          nv_addr  <= load_idx;
          load_idx <= NV_AW'(load_idx + 1'b1);
          if (load_idx == NV_AW'(DEPTH - 1)) begin
            state      <= SETTLE_W;
            settle_cnt <= '0;
          end
        end
        SETTLE_W: begin
          // Lets the last read land and the strap node settle
          settle_cnt <= 16'(settle_cnt + 1'b1);
          if (settle_cnt >= 16'(SETTLE - 1)) begin
            state     <= CONVERT;
            adc_start <= 1'b1;
          end
        end
        CONVERT: begin
          if (strap_done) begin
            state <= DONE;
          end
        end
        DONE: begin
          if (!por_ok) begin
            state <= HOLD;
          end
        end
      endcase
      if (!por_ok) begin
        state     <= HOLD;
        nv_read   <= 1'b0;
        adc_start <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      load_pend <= 1'b0;
      pend_idx  <= '0;
    end else begin
      load_pend <= nv_read;
      pend_idx  <= nv_addr;
    end
  end

  // commands after load; ignored in analog mode
  assign cmd_ok = load_done && digital_mode && cmd_write;

  // base address registers within working set
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < DEPTH; i++) begin
        cfg_word[i] <= '0;
      end
      cfg_word[TWO_WIRE_SLOT] <= CFG_W'(TWO_WIRE_RESET);
      cfg_word[MGMT_BUS_SLOT] <= CFG_W'(MGMT_BUS_RESET);
    end else if (load_pend) begin
      cfg_word[pend_idx] <= nv_data;
    end else if (cmd_ok) begin
      cfg_word[cmd_slot] <= cmd_data;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      load_done <= 1'b0;
    end else begin
      load_done <= (state == SETTLE_W) || (state == CONVERT) || (state == DONE);
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      two_wire_address <= TWO_WIRE_RESET;
      mgmt_bus_address <= MGMT_BUS_RESET;
    end else begin
      two_wire_address <= cfg_word[TWO_WIRE_SLOT][ADDR_W-1:0];
      mgmt_bus_address <= cfg_word[MGMT_BUS_SLOT][ADDR_W-1:0];
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      addr_read    <= 1'b0;
      eff_two_wire <= '0;
      eff_mgmt     <= '0;
      digital_mode <= 1'b0;
      analog_pins  <= 1'b0;
    end else if (state == HOLD) begin
      addr_read    <= 1'b0;
      digital_mode <= 1'b0;
      analog_pins  <= 1'b0;
    end else if (state == CONVERT && strap_done && !addr_read) begin
      addr_read    <= 1'b1;
      eff_two_wire <= add_offset(cfg_word[TWO_WIRE_SLOT][ADDR_W-1:0], strap_offset);
      eff_mgmt     <= add_offset(cfg_word[MGMT_BUS_SLOT][ADDR_W-1:0], strap_offset);
      digital_mode <= !strap_float;
      analog_pins  <= strap_float;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      addr_match <= 1'b0;
    end else begin
      addr_match <= digital_mode && rx_addr.valid && (rx_addr.addr != '0) &&
                    (rx_addr.addr == (rx_addr.is_mgmt ? eff_mgmt : eff_two_wire));
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      convert_enable <= 1'b0;
    end else if (digital_mode && enables.sw_override) begin
      convert_enable <= enables.sw_enable && load_done && addr_read;
    end else begin
      convert_enable <= enables.enable_mode_pin && enables.bus_voltage_ok && load_done && addr_read;
    end
  end
endmodule // power_up_init_and_address_select

// file: sim/nv_adc_model.sv
// Far-side model: memory read port and strap converter
`timescale 1ns/1ps
module nv_adc_model
  import init_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              rst_b,
  input  wire logic [NV_AW-1:0]  nv_addr,
  input  wire logic              nv_read,
  input  wire logic              adc_start,
  input  wire logic [CODE_W-1:0] strap,
  output logic [CFG_W-1:0]       nv_data,
  output logic                   adc_valid,
  output logic [CODE_W-1:0]      adc_code
);
  logic [2:0] wait_cnt;
  // Data holds one cycle only; toggles after so stale use shows up
  always_ff @(posedge clk) begin
    if (nv_read) begin
      nv_data <= (nv_addr == 3'h0) ? 16'h0010 : (nv_addr == 3'h1) ? 16'h0040 : {13'h1860, nv_addr};
    end else begin
      nv_data <= ~nv_data;
    end
  end
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wait_cnt <= 3'h0;
      adc_valid <= 1'b0;
    end else begin
      adc_valid <= (wait_cnt == 3'h1);
      wait_cnt <= adc_start ? 3'h3 : (wait_cnt != 3'h0) ? wait_cnt - 3'h1 : 3'h0;
    end
  end
  assign adc_code = adc_valid ? strap : ~strap;
endmodule // nv_adc_model

// file: sim/init_monitor.sv
// Checker: port timing of power-up init and address select
`timescale 1ns/1ps
module init_monitor
  import init_pkg::*;
#(
  parameter int DEPTH = NV_DEPTH
) (
  input wire logic              clk,
  input wire logic              rst_b,
  input wire supply_s           supplies,
  input wire enable_s           enables,
  input wire logic [NV_AW-1:0]  nv_addr,
  input wire logic              nv_read,
  input wire logic              adc_valid,
  input wire logic              cmd_write,
  input wire bus_addr_s         rx_addr,
  input wire logic              addr_match,
  input wire logic              digital_mode,
  input wire logic              analog_pins,
  input wire logic              load_done,
  input wire logic              addr_read,
  input wire logic              convert_enable,
  input wire logic [ADDR_W-1:0] two_wire_address
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  logic [4:0] rd_cnt;
  // Reads of one load; a supply drop restarts the count
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) rd_cnt <= 5'h00;
    else if (!(&supplies)) rd_cnt <= 5'h00;
    else if (nv_read) rd_cnt <= rd_cnt + 5'h01;
  end
  sequence s_down;
    !(&supplies) [*3];
  endsequence
  a_hold_no_read: assert property (s_down |-> !nv_read) else $error("read while supplies down");
  a_full_load: assert property ($rose(load_done) |-> rd_cnt == 5'(DEPTH)) else $error("load size");
  a_read_order: assert property (nv_read && $past(nv_read) |-> nv_addr == 3'($past(nv_addr) + 1))
    else $error("read order");
  a_early_cmd: assert property (!load_done && cmd_write && !$past(nv_read) |=> $stable(two_wire_address))
    else $error("early write");
  a_pin_gate: assert property (!$past(enables.sw_override && digital_mode) |-> convert_enable ==
    $past(enables.enable_mode_pin && enables.bus_voltage_ok && load_done && addr_read)) else $error("gate");
  a_sw_gate: assert property ($past(enables.sw_override && digital_mode) |-> convert_enable == $past(enables.sw_enable))
    else $error("override");
  a_strap_read: assert property ($rose(addr_read) |-> $past(adc_valid, 2)) else $error("address not read");
  a_analog_deaf: assert property (analog_pins && $past(analog_pins) |-> !addr_match) else $error("analog answer");
  a_mode_excl: assert property (!(digital_mode && analog_pins)) else $error("both modes");
  a_analog_frozen: assert property (analog_pins && cmd_write |=> $stable(two_wire_address)) else $error("frozen");
  a_no_rx_match: assert property (!$past(rx_addr.valid) |-> !addr_match) else $error("spurious match");
endmodule // init_monitor
bind power_up_init_and_address_select init_monitor #(.DEPTH(DEPTH)) mon (.clk, .rst_b, .supplies, .enables, .nv_addr,
  .nv_read, .adc_valid, .cmd_write, .rx_addr, .addr_match, .digital_mode, .analog_pins, .load_done, .addr_read,
  .convert_enable, .two_wire_address);

// file: sim/tb_top.sv
// Bench: boots over several straps, checks addressing, mode and gating
`timescale 1ns/1ps
module tb_top;
  import init_pkg::*;
  logic              clk, rst_b, nv_read, adc_start, adc_valid, cmd_write, addr_match;
  logic              digital_mode, analog_pins, load_done, addr_read, convert_enable;
  supply_s           supplies;
  enable_s           enables;
  bus_addr_s         rx_addr;
  logic [NV_AW-1:0]  nv_addr, cmd_slot;
  logic [CFG_W-1:0]  nv_data, cmd_data;
  logic [CFG_W-1:0]  cfg_word [NV_DEPTH];
  logic [CODE_W-1:0] adc_code, strap;
  logic [ADDR_W-1:0] two_wire_address, mgmt_bus_address, eff;
  int                n_fail, checks_done, i, k;
  // Floating, top of band 0, top band, bottom of band 1; last stays digital
  logic [CODE_W-1:0] codes [4] = '{10'h3C0, 10'h03B, 10'h3BF, 10'h03C};
  logic [3:0]        offs [4] = '{4'h0, 4'h0, 4'hF, 4'h1};
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  power_up_init_and_address_select #(.SETTLE(4)) uut (.clk, .rst_b, .supplies, .enables, .nv_addr, .nv_read,
    .nv_data, .adc_start, .adc_valid, .adc_code, .cmd_write, .cmd_slot, .cmd_data, .rx_addr, .addr_match,
    .digital_mode, .analog_pins, .load_done, .addr_read, .convert_enable, .two_wire_address, .mgmt_bus_address,
    .cfg_word);
  nv_adc_model far (.clk, .rst_b, .nv_addr, .nv_read, .adc_start, .strap, .nv_data, .adc_valid, .adc_code);
  task chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task results;
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task wr(input logic [NV_AW-1:0] slot, input logic [CFG_W-1:0] data);
    cmd_write = 1'b1;
    cmd_slot = slot;
    cmd_data = data;
    @(negedge clk);
    cmd_write = 1'b0;
    @(negedge clk);
  endtask
  task rx(input logic [6:0] a, input logic mgmt, input logic exp);
    rx_addr = '{1'b1, a, mgmt};
    @(negedge clk);
    rx_addr.valid = 1'b0;
    chk("addr_match", addr_match, exp);
    @(negedge clk);
  endtask
  task gate(input enable_s e, input logic exp);
    enables = e;
    repeat (2) @(negedge clk);
    chk("convert_enable", convert_enable, exp);
  endtask
  task boot(input logic [CODE_W-1:0] code);
    rst_b = 1'b0;
    supplies = '0;
    strap = code;
    repeat (16) @(negedge clk);
    rst_b = 1'b1;
    wr(TWO_WIRE_SLOT, 16'h0077);
    repeat (20) @(negedge clk);
    chk("load_done", load_done, 1'b0);
    supplies = 3'b111;
    for (i = 0; i < 99 && addr_read !== 1'b1; i++) @(negedge clk);
    if (addr_read !== 1'b1) begin
      n_fail++;
      results();
    end
    // Early write must not survive the load
    for (i = 0; i < NV_DEPTH; i++) chk("cfg_word", cfg_word[i], i == 0 ? 16'h10 : i == 1 ? 16'h40 : 16'hC300 | i);
  endtask
  initial begin
    rst_b = 1'b0;
    supplies = '0;
    enables = '0;
    cmd_write = 1'b0;
    cmd_slot = '0;
    cmd_data = '0;
    rx_addr = '0;
    strap = '0;
    for (k = 0; k < 4; k++) begin
      boot(codes[k]);
      eff = 7'h10 + 7'(offs[k]);
      chk("analog_pins", analog_pins, k == 0);
      chk("digital_mode", digital_mode, k != 0);
      rx(eff, 1'b0, k != 0);
      rx(7'h30 + eff, 1'b1, k != 0);
      rx(eff - 7'h01, 1'b0, 1'b0);
      wr(TWO_WIRE_SLOT, 16'h0055);
      wr(MGMT_BUS_SLOT, 16'h0033);
      chk("two_wire", two_wire_address, k == 0 ? 7'h10 : 7'h55);
      chk("mgmt_bus", mgmt_bus_address, k == 0 ? 7'h40 : 7'h33);
    end
    // Supply loss mid-run: back to hold, then a fresh load and strap read
    supplies = '0;
    repeat (4) @(negedge clk);
    chk("load_done", load_done, 1'b0);
    chk("addr_read", addr_read, 1'b0);
    chk("digital_mode", digital_mode, 1'b0);
    supplies = 3'b111;
    for (i = 0; i < 99 && addr_read !== 1'b1; i++) @(negedge clk);
    chk("addr_read", addr_read, 1'b1);
    chk("two_wire", two_wire_address, 7'h10);
    rx(7'h11, 1'b0, 1'b1);
    gate(4'b1100, 1'b1);
    gate(4'b0100, 1'b0);
    gate(4'b0011, 1'b1);
    gate(4'b1110, 1'b0);
    results();
  end
endmodule // tb_top
